// ==== src/dfre_dec_alu.sv ====
/*
 * Byte decrement unit with status flags.
 * Purely combinational; the caller registers whatever it keeps.
 */
`timescale 1ns/1ns
module dfre_dec_alu (
	input  wire logic [7:0]           operand,
	output dfre_pkg::dfre_alu_out_t   alu_out
);
	logic [7:0] diff;

	always_comb begin
		diff = operand - 8'h01;
		alu_out.result = diff;
		// carry and digit carry mean "no borrow", as for any subtract
		alu_out.flags.carry = (operand != 8'h00);
		alu_out.flags.dc = (operand[3:0] != 4'h0);
		alu_out.flags.zero = (diff == 8'h00);
		alu_out.flags.neg = diff[7];
		alu_out.flags.ovf = (operand == 8'h80);
	end
endmodule : dfre_dec_alu

// ==== src/dfre_pkg.sv ====
/*
 * Constants, register map and carrier types for the decrement-memory
 * execution block. Assumes an AHB-Lite master on hclk and a core that
 * hands over one instruction word at a time through the exec register.
 */
// Notes on behaviour
// - result is the addressed memory byte minus one, sent to the selected destination.
// - destination bit 0 writes accumulator; memory location stays unchanged.
// - destination bit 1 writes result back to the operand's own location.
// - access bit 0 resolves address in fixed access bank, bank register ignored.
// - access bit 1 joins bank register and address field to pick a bank.
// - extended set on, access bit 0, field at most 5Fh: indexed literal offset.
package dfre_pkg;

	localparam int unsigned BANK_BITS_DEF = 4;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_BANK     = 8'h04;
	localparam logic [7:0] OFF_WREG     = 8'h08;
	localparam logic [7:0] OFF_INDEX    = 8'h0C;
	localparam logic [7:0] OFF_STATUS   = 8'h10;
	localparam logic [7:0] OFF_EXEC     = 8'h14;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h18;
	localparam logic [7:0] OFF_MEM_DATA = 8'h1C;

	// instruction fields
	localparam logic [5:0]  OPC_DEC_MEM   = 6'h01;
	localparam int unsigned POS_OPC_LO    = 10;
	localparam int unsigned POS_DEST      = 9;
	localparam int unsigned POS_ACCESS    = 8;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h5F;
	localparam int unsigned POS_ILLEGAL   = 16;

	// reset values
	localparam logic [7:0]  WREG_RST   = 8'h00;
	localparam logic [15:0] INSTR_RST  = 16'h0000;
	localparam logic [4:0]  FLAGS_RST  = 5'h00;

	typedef struct packed {
		logic neg;
		logic ovf;
		logic zero;
		logic dc;
		logic carry;
	} dfre_flags_t;

	typedef struct packed {
		logic [7:0]  result;
		dfre_flags_t flags;
	} dfre_alu_out_t;

endpackage : dfre_pkg

// ==== src/dfre_top.sv ====
/*
 * Decrement-memory execution block with its data memory and an AHB-Lite
 * register slave. A write of an instruction word to the exec register
 * runs it in that same data phase. Assumes a single AHB-Lite master,
 * word transfers only.
 */
`timescale 1ns/1ns
module dfre_top #(
	parameter int unsigned BANK_BITS = dfre_pkg::BANK_BITS_DEF
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	localparam int unsigned ADDR_W    = BANK_BITS + 8;
	localparam int unsigned MEM_DEPTH = 1 << ADDR_W;

	typedef struct packed {
		logic                 ext_set_en;
		logic [BANK_BITS-1:0] bank_select_reg;
		logic [7:0]           wreg;
		logic [ADDR_W-1:0]    index_base;
		dfre_pkg::dfre_flags_t flags;
		logic [15:0]          last_instr;
		logic                 illegal;
		logic [ADDR_W-1:0]    mem_addr;
		logic                 ph_valid;
		logic                 ph_write;
		logic [7:0]           ph_addr;
		logic                 rd_wait;
		logic [31:0]          rdata;
	} dfre_state_t;

	dfre_state_t s_r;
	dfre_state_t s_nxt;

	logic [7:0]            general_purpose_ram [MEM_DEPTH];
	logic [15:0]           instr;
	logic [7:0]            field_f;
	logic [ADDR_W-1:0]     op_addr;
	logic [7:0]            operand;
	dfre_pkg::dfre_alu_out_t alu_out;
	logic                  wr_phase;
	logic                  decrement_mem_op;
	logic                  mem_we;
	logic [ADDR_W-1:0]     mem_wa;
	logic [7:0]            mem_wd;
	logic [31:0]           rd_mux;

	assign instr = hwdata[15:0];
	assign field_f = instr[7:0];
	assign wr_phase = s_r.ph_valid && s_r.ph_write && hready;
	assign decrement_mem_op = wr_phase && (s_r.ph_addr == dfre_pkg::OFF_EXEC)
		&& (instr[15:dfre_pkg::POS_OPC_LO] == dfre_pkg::OPC_DEC_MEM);

	// operand address resolution
	always_comb begin
		if (instr[dfre_pkg::POS_ACCESS]) begin
			op_addr = {s_r.bank_select_reg, field_f};
		end else if (s_r.ext_set_en && (field_f <= dfre_pkg::ACCESS_SPLIT)) begin
			op_addr = s_r.index_base + ADDR_W'(field_f);
		end else if (field_f <= dfre_pkg::ACCESS_SPLIT) begin
			op_addr = {{BANK_BITS{1'b0}}, field_f};
		end else begin
			// upper part of the access bank maps onto the top bank
			op_addr = {{BANK_BITS{1'b1}}, field_f};
		end
	end

	assign operand = general_purpose_ram[op_addr];

	dfre_dec_alu u_alu (
		.operand (operand),
		.alu_out (alu_out)
	);

	// single memory write port shared by bus and instruction
	always_comb begin
		mem_we = 1'b0;
		mem_wa = s_r.mem_addr;
		mem_wd = hwdata[7:0];
		if (decrement_mem_op && instr[dfre_pkg::POS_DEST]) begin
			mem_we = 1'b1;
			mem_wa = op_addr;
			mem_wd = alu_out.result;
		end else if (wr_phase && (s_r.ph_addr == dfre_pkg::OFF_MEM_DATA)) begin
			mem_we = 1'b1;
		end
	end

	always_ff @(posedge hclk) begin
		if (mem_we) begin
			general_purpose_ram[mem_wa] <= mem_wd;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_r.ph_addr)
			dfre_pkg::OFF_CTRL:     rd_mux[0] = s_r.ext_set_en;
			dfre_pkg::OFF_BANK:     rd_mux[BANK_BITS-1:0] = s_r.bank_select_reg;
			dfre_pkg::OFF_WREG:     rd_mux[7:0] = s_r.wreg;
			dfre_pkg::OFF_INDEX:    rd_mux[ADDR_W-1:0] = s_r.index_base;
			dfre_pkg::OFF_STATUS:   rd_mux[4:0] = s_r.flags;
			dfre_pkg::OFF_EXEC: begin
				rd_mux[15:0] = s_r.last_instr;
				rd_mux[dfre_pkg::POS_ILLEGAL] = s_r.illegal;
			end
			dfre_pkg::OFF_MEM_ADDR: rd_mux[ADDR_W-1:0] = s_r.mem_addr;
			dfre_pkg::OFF_MEM_DATA: rd_mux[7:0] = general_purpose_ram[s_r.mem_addr];
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// register writes, zero wait states
		if (wr_phase) begin
			case (s_r.ph_addr)
				dfre_pkg::OFF_CTRL:     s_nxt.ext_set_en = hwdata[0];
				dfre_pkg::OFF_BANK:     s_nxt.bank_select_reg = hwdata[BANK_BITS-1:0];
				dfre_pkg::OFF_WREG:     s_nxt.wreg = hwdata[7:0];
				dfre_pkg::OFF_INDEX:    s_nxt.index_base = hwdata[ADDR_W-1:0];
				dfre_pkg::OFF_STATUS:   s_nxt.flags = hwdata[4:0];
				dfre_pkg::OFF_MEM_ADDR: s_nxt.mem_addr = hwdata[ADDR_W-1:0];
				dfre_pkg::OFF_EXEC: begin
					s_nxt.last_instr = instr;
					// any other opcode is recorded but has no effect
					s_nxt.illegal = !decrement_mem_op;
				end
				default: s_nxt.illegal = s_r.illegal;
			endcase
		end
		if (decrement_mem_op) begin
			s_nxt.flags = alu_out.flags;
			if (!instr[dfre_pkg::POS_DEST]) begin
				s_nxt.wreg = alu_out.result;
			end
		end
		// reads take one wait state so a preceding write is always seen
		if (s_r.rd_wait) begin
			s_nxt.rdata = rd_mux;
			s_nxt.rd_wait = 1'b0;
		end
		if (hready) begin
			s_nxt.ph_valid = hsel && htrans[1];
			s_nxt.ph_write = hwrite;
			s_nxt.ph_addr = haddr[7:0];
			s_nxt.rd_wait = hsel && htrans[1] && !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r.ext_set_en <= 1'b0;
			s_r.bank_select_reg <= '0;
			s_r.wreg <= dfre_pkg::WREG_RST;
			s_r.index_base <= '0;
			s_r.flags <= dfre_pkg::FLAGS_RST;
			s_r.last_instr <= dfre_pkg::INSTR_RST;
			s_r.illegal <= 1'b0;
			s_r.mem_addr <= '0;
			s_r.ph_valid <= 1'b0;
			s_r.ph_write <= 1'b0;
			s_r.ph_addr <= 8'h00;
			s_r.rd_wait <= 1'b0;
			s_r.rdata <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hreadyout = !s_r.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = s_r.rdata;
endmodule : dfre_top

// ==== test/dfre_top_assertions.sv ====
/*
 * Bus timing checker for dfre_top, bound to its ports.
 * Assumes hready is tied back to hreadyout by the surroundings.
 */
`timescale 1ns/1ns
module dfre_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_t;
	logic wr_t;
	assign rd_t = hsel && htrans[1] && hready && !hwrite;
	assign wr_t = hsel && htrans[1] && hready && hwrite;
	read_wait_a: assert property (rd_t |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	write_fast_a: assert property (wr_t |=> hreadyout)
		else $error("write data phase stalled");
	stall_once_a: assert property (!hreadyout |=> hreadyout)
		else $error("stall longer than one cycle");
	stall_cause_a: assert property ($fell(hreadyout) |-> $past(rd_t))
		else $error("stall without a read");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved outside a read");
	cover property (rd_t);
	cover property (wr_t);
	cover property (!hreadyout);
endmodule : dfre_assertions

bind dfre_top dfre_assertions u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata);

// ==== test/dfre_top_tb.sv ====
/*
 * Self-checking bench for dfre_top: random decrements against a model.
 * Assumes this bench is the lone AHB-Lite master, hready from hreadyout.
 */
`timescale 1ns/1ns
module dfre_top_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	int          err_count = 0, check_count = 0;
	always #5 hclk = ~hclk;
	dfre_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata);
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task tally_and_finish;
		if (err_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// ready seen at negedge is what the next rising edge samples
	task wt;
		int i;
		for (i = 0; i < 20; i++) begin
			@(negedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (i == 20) begin
			chk(32'h0, 32'h1);
			tally_and_finish;
		end
		@(posedge hclk);
	endtask : wt
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		q = hrdata;
	endtask : bus
	task rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
		chk({31'h0, hresp}, 32'h0);
	endtask : rc
	initial begin
		logic [7:0]  op, f, wr;
		logic [5:0]  opc;
		logic [3:0]  bk;
		logic [11:0] ix, ad;
		logic [31:0] r, s;
		logic        d, a, x;
		int          mdl_mem [int];
		int          exp_q [$];
		int          m_op, m_res, m_wreg, m_flags, m_ill;
		void'($urandom(69));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc(8'h20, 32'h0);
		rc(dfre_pkg::OFF_EXEC, 32'h0);
		for (int n = 0; n < 48; n++) begin
			r = $urandom;
			s = $urandom;
			{d, a, x, bk, ix, wr} = r[26:0];
			op = n % 4 == 0 ? 8'h00 : n % 4 == 1 ? 8'h80 : s[15:8];
			f = n % 3 == 0 ? 8'h5F : n % 3 == 1 ? 8'h60 : s[7:0];
			// bit 1 set never matches the decrement opcode
			opc = n % 8 == 7 ? s[21:16] | 6'h02 : dfre_pkg::OPC_DEC_MEM;
			ad = a ? {bk, f} : x && f <= 8'h5F ? ix + f : f <= 8'h5F ? {4'h0, f} : {4'hF, f};
			// integer model of one instruction
			m_op = op;
			m_res = (m_op + 255) % 256;
			m_wreg = wr;
			m_flags = s[28:24];
			m_ill = (opc != dfre_pkg::OPC_DEC_MEM) ? 1 : 0;
			mdl_mem[ad] = m_op;
			if (m_ill == 0) begin
				if (d) begin
					mdl_mem[ad] = m_res;
				end else begin
					m_wreg = m_res;
				end
				m_flags = (m_res >= 128 ? 16 : 0) + (m_op == 128 ? 8 : 0) + (m_res == 0 ? 4 : 0)
					+ (m_op % 16 != 0 ? 2 : 0) + (m_op != 0 ? 1 : 0);
			end
			bus(1'b1, dfre_pkg::OFF_CTRL, {31'h0, x});
			bus(1'b1, dfre_pkg::OFF_BANK, {28'h0, bk});
			bus(1'b1, dfre_pkg::OFF_INDEX, {20'h0, ix});
			bus(1'b1, dfre_pkg::OFF_WREG, {24'h0, wr});
			bus(1'b1, dfre_pkg::OFF_STATUS, {27'h0, s[28:24]});
			bus(1'b1, dfre_pkg::OFF_MEM_ADDR, {20'h0, ad});
			bus(1'b1, dfre_pkg::OFF_MEM_DATA, {24'h0, op});
			bus(1'b1, dfre_pkg::OFF_EXEC, {16'h0, opc, d, a, f});
			exp_q.push_back(m_wreg);
			exp_q.push_back(mdl_mem[ad]);
			exp_q.push_back(m_flags);
			exp_q.push_back((m_ill << dfre_pkg::POS_ILLEGAL) + {opc, d, a, f});
			rc(dfre_pkg::OFF_WREG, exp_q.pop_front());
			rc(dfre_pkg::OFF_MEM_DATA, exp_q.pop_front());
			rc(dfre_pkg::OFF_STATUS, exp_q.pop_front());
			rc(dfre_pkg::OFF_EXEC, exp_q.pop_front());
			rc(dfre_pkg::OFF_CTRL, {31'h0, x});
			rc(dfre_pkg::OFF_BANK, {28'h0, bk});
			rc(dfre_pkg::OFF_INDEX, {20'h0, ix});
			rc(dfre_pkg::OFF_MEM_ADDR, {20'h0, ad});
		end
		tally_and_finish;
	end
endmodule : dfre_top_tb
